/* File: hw/cad_pkg.sv */
// Package of constants and types for the CPU arithmetic datapath.
package cad_pkg;
    // Register byte addresses on the AHB-Lite bus.
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_OP_A = 8'h08;
    localparam logic [7:0] ADDR_OP_B = 8'h0c;
    localparam logic [7:0] ADDR_OP_HI = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_RES_LO = 8'h18;
    localparam logic [7:0] ADDR_RES_HI = 8'h1c;
    localparam logic [7:0] ADDR_BUSY = 8'h20;
    // Status flag bit positions.
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_OV = 2;
    localparam int FLG_N = 3;
    localparam int FLG_RA = 4;
    localparam int FLG_IPL = 5;
    localparam int FLG_DC = 8;
    // Control bit positions.
    localparam int CTL_PSV = 2;
    localparam int CTL_PRIORITY_LEVEL_MSB = 3;
    // Reset values and implemented masks.
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_MASK = 16'h01ff;
    // Command word fields: op in [3:0], byte size in [4], shift count in [11:8].
    localparam int CMD_BYTE = 4;
    localparam int CMD_CNT = 8;
    // Divide timing: total cycles and iterations.
    localparam int DIV_TOTAL = 19;
    localparam int DIV_ITER = 16;
    // Operations.
    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
        OP_ASR, OP_SL, OP_LSR,
        OP_MUL_SS, OP_MUL_UU, OP_MUL_US, OP_MUL_SU, OP_MUL_B,
        OP_DIV_S, OP_DIV_U, OP_NOP
    } cad_op_e;
endpackage

/* File: hw/cad_alu_datapath.sv */
// CPU arithmetic datapath with status, control and divider, behind AHB-Lite.
// Summary of operation
// - Half carry from bit 4 in byte mode, bit 8 in word mode.
// - Three low priority bits give levels 0 to 7; all ones masks user interrupts.
// - Control top bit sits above low bits forming levels 8 to 15.
// - Low priority bits ignore writes while nesting disable is one.
// - Loop-active bit is read-only, one while a repeat loop runs.
// - Negative flag follows sign of the result.
// - Overflow flag marks two's complement signed overflow.
// - Zero flag stays set until a non-zero result clears it.
// - Carry flag marks carry out of the most significant bit.
// - Status bits 15 to 9 read zero; all implemented bits reset zero.
// - Priority top bit reads one above 7, software clear only, masks interrupts.
// - Control bit 2 enables program space window in data space.
// - Sixteen-bit unit: add, subtract, shifts, logic, two's complement.
// - Carry and half carry act as borrow flags for subtraction.
// - Byte or word size chosen per operation; operands from registers.
// - Multiplier handles signed, unsigned, mixed, literal and byte modes; the code has no literal mode.
// - Divider handles signed and unsigned 32 or 16 bit by 16 bit.
// - Quotient goes to work register 0, remainder to work register 1.
// - Divisor from any register; 32-bit dividend from even-odd pair.
// - One iteration per divisor bit; both dividend sizes take equal time.
// - Barrel shifter shifts right arithmetic or left up to 15 in a cycle.
// - Multi-bit shifts use register operands and results only.
// - Shifter offers arithmetic right, left and logical right.
// - Each divide takes 19 cycles and may be abandoned at a boundary.
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cad_alu_datapath (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core context.
    input wire logic nestingDisable,
    input wire logic loopActive,
    input wire logic ipl3Raise,
    input wire logic divAbort,
    // Datapath outputs.
    output logic [3:0] cpuPriority,
    output logic userIntDisabled,
    output logic progWindowEnable,
    output logic [15:0] workReg0,
    output logic [15:0] workReg1,
    output logic divBusy
);
    // Complete register state of the block.
    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] ctrl;
        logic [15:0] opA;
        logic [15:0] opB;
        logic [15:0] opHi;
        logic [31:0] res;
        logic apValid;
        logic apWrite;
        logic [7:0] apAddr;
        logic [31:0] rdata;
        logic divRun;
        logic [4:0] divCnt;
        logic divSigned;
        logic divNegQ;
        logic divNegR;
        logic [31:0] divRem;
        logic [15:0] divDen;
    } cad_state_s;

    cad_state_s st_q;
    cad_state_s st_d;

    logic [15:0] curFlags;
    logic [15:0] hiA;
    logic [15:0] cmdWord;
    cad_pkg::cad_op_e cmdOp;
    logic byteMode;
    logic [3:0] shCnt;
    logic [16:0] sum;
    logic [15:0] rVal;
    logic [15:0] bVal;
    logic [4:0] hBit;
    logic cOut;
    logic vOut;
    logic [33:0] prod;
    logic signed [16:0] mA;
    logic signed [16:0] mB;
    logic [31:0] dvd;
    logic [32:0] trial;
    logic [15:0] absDen;
    logic wrEn;

    // Combinational next-state of bus, flags, datapath and divider.
    always_comb begin
        st_d = st_q;
        curFlags = st_q.flags;
        curFlags[cad_pkg::FLG_RA] = loopActive;
        wrEn = st_q.apValid && st_q.apWrite;
        cmdWord = hwdata[15:0];
        cmdOp = cad_pkg::cad_op_e'(cmdWord[3:0]);
        byteMode = cmdWord[cad_pkg::CMD_BYTE];
        shCnt = cmdWord[cad_pkg::CMD_CNT +: 4];
        hiA = st_q.opA;
        sum = 17'h00000;
        rVal = 16'h0000;
        bVal = st_q.opB;
        hBit = 5'h00;
        cOut = 1'b0;
        vOut = 1'b0;
        prod = 34'h000000000;
        mA = 17'sh00000;
        mB = 17'sh00000;
        dvd = 32'h00000000;
        trial = 33'h000000000;
        absDen = 16'h0000;
        // Address phase capture.
        st_d.apValid = hsel && hready && htrans[1];
        if (hsel && hready) begin
            st_d.apWrite = hwrite;
            st_d.apAddr = haddr;
        end
        st_d.flags[cad_pkg::FLG_RA] = loopActive;
        // Hardware raise of the priority top bit.
        if (ipl3Raise) begin
            st_d.ctrl[cad_pkg::CTL_PRIORITY_LEVEL_MSB] = 1'b1;
        end
        // Register writes from the bus.
        if (wrEn) begin
            unique case (st_q.apAddr)
                cad_pkg::ADDR_FLAGS: begin
                    st_d.flags[cad_pkg::FLG_DC] = hwdata[cad_pkg::FLG_DC];
                    st_d.flags[3:0] = hwdata[3:0];
                    if (!nestingDisable) begin
                        st_d.flags[cad_pkg::FLG_IPL +: 3] = hwdata[cad_pkg::FLG_IPL +: 3];
                    end
                end
                cad_pkg::ADDR_CTRL: begin
                    st_d.ctrl[cad_pkg::CTL_PSV] = hwdata[cad_pkg::CTL_PSV];
                    if (!hwdata[cad_pkg::CTL_PRIORITY_LEVEL_MSB] && !ipl3Raise) begin
                        st_d.ctrl[cad_pkg::CTL_PRIORITY_LEVEL_MSB] = 1'b0;
                    end
                end
                cad_pkg::ADDR_OP_A: st_d.opA = hwdata[15:0];
                cad_pkg::ADDR_OP_B: st_d.opB = hwdata[15:0];
                cad_pkg::ADDR_OP_HI: st_d.opHi = hwdata[15:0];
                cad_pkg::ADDR_CMD: begin
                    if (!st_q.divRun) begin
                        // Byte mode masks the add, subtract and logic operands to the low byte.
                        if (byteMode) begin
                            hiA = {8'h00, st_q.opA[7:0]};
                            bVal = {8'h00, st_q.opB[7:0]};
                            hBit = 5'd4;
                        end else begin
                            hBit = 5'd8;
                        end
                        unique case (cmdOp)
                            cad_pkg::OP_ADD, cad_pkg::OP_SUB: begin
                                if (cmdOp == cad_pkg::OP_SUB) begin
                                    bVal = byteMode ? {8'h00, ~bVal[7:0]} : ~bVal;
                                end
                                sum = {1'b0, hiA} + {1'b0, bVal}
                                    + {16'h0000, cmdOp == cad_pkg::OP_SUB};
                                rVal = sum[15:0];
                                // Half carry out of the selected digit boundary.
                                curFlags[cad_pkg::FLG_DC] = byteMode
                                    ? ((hiA[3:0] + bVal[3:0]
                                        + {3'h0, cmdOp == cad_pkg::OP_SUB}) > 5'h0f)
                                    : ((hiA[7:0] + bVal[7:0]
                                        + {7'h00, cmdOp == cad_pkg::OP_SUB}) > 9'h0ff);
                                cOut = byteMode ? sum[8] : sum[16];
                                vOut = byteMode
                                    ? (hiA[7] == bVal[7]) && (rVal[7] != hiA[7])
                                    : (hiA[15] == bVal[15]) && (rVal[15] != hiA[15]);
                                curFlags[cad_pkg::FLG_C] = cOut;
                                curFlags[cad_pkg::FLG_OV] = vOut;
                            end
                            cad_pkg::OP_AND: rVal = hiA & bVal;
                            cad_pkg::OP_IOR: rVal = hiA | bVal;
                            cad_pkg::OP_XOR: rVal = hiA ^ bVal;
                            cad_pkg::OP_ASR: rVal = 16'($signed(st_q.opA) >>> shCnt);
                            cad_pkg::OP_SL: rVal = st_q.opA << shCnt;
                            cad_pkg::OP_LSR: rVal = st_q.opA >> shCnt;
                            cad_pkg::OP_MUL_SS, cad_pkg::OP_MUL_UU, cad_pkg::OP_MUL_US,
                            cad_pkg::OP_MUL_SU, cad_pkg::OP_MUL_B: begin
                                // Seventeen-bit operands: sign or zero extended per mode.
                                mA = {(cmdOp == cad_pkg::OP_MUL_SS || cmdOp == cad_pkg::OP_MUL_SU)
                                    && st_q.opA[15], st_q.opA};
                                mB = {(cmdOp == cad_pkg::OP_MUL_SS || cmdOp == cad_pkg::OP_MUL_US)
                                    && st_q.opB[15], st_q.opB};
                                if (cmdOp == cad_pkg::OP_MUL_B) begin
                                    mA = {9'h000, st_q.opA[7:0]};
                                    mB = {9'h000, st_q.opB[7:0]};
                                end
                                prod = 34'(mA * mB);
                                st_d.res = prod[31:0];
                            end
                            cad_pkg::OP_DIV_S, cad_pkg::OP_DIV_U: begin
                                // Dividend: high word from the pair, or sign or zero extension of the low word.
                                st_d.divSigned = (cmdOp == cad_pkg::OP_DIV_S);
                                dvd = byteMode
                                    ? {(cmdOp == cad_pkg::OP_DIV_S && st_q.opA[15])
                                        ? 16'hffff : 16'h0000, st_q.opA}
                                    : {st_q.opHi, st_q.opA};
                                absDen = st_q.opB;
                                if (cmdOp == cad_pkg::OP_DIV_S) begin
                                    st_d.divNegQ = dvd[31] ^ st_q.opB[15];
                                    st_d.divNegR = dvd[31];
                                    if (dvd[31]) begin
                                        dvd = -dvd;
                                    end
                                    if (st_q.opB[15]) begin
                                        absDen = -st_q.opB;
                                    end
                                end else begin
                                    st_d.divNegQ = 1'b0;
                                    st_d.divNegR = 1'b0;
                                end
                                st_d.divRem = dvd;
                                st_d.divDen = absDen;
                                st_d.divRun = 1'b1;
                                st_d.divCnt = 5'(cad_pkg::DIV_TOTAL - 1);
                            end
                            default: rVal = 16'h0000;
                        endcase
                        // Result flags for the add, subtract, logic and shift operations.
                        if (cmdOp <= cad_pkg::OP_LSR) begin
                            if (byteMode) begin
                                rVal = {8'h00, rVal[7:0]};
                            end
                            st_d.res = {16'h0000, rVal};
                            curFlags[cad_pkg::FLG_N] = byteMode ? rVal[7] : rVal[15];
                            curFlags[cad_pkg::FLG_Z] = (rVal == 16'h0000);
                        end
                        st_d.flags = {curFlags[15:5], loopActive, curFlags[3:0]};
                    end
                end
                default: begin
                end
            endcase
        end
        // Iterative divide: 16 restoring steps inside the 19-cycle window.
        if (st_q.divRun) begin
            st_d.divCnt = st_q.divCnt - 5'd1;
            if (st_q.divCnt <= 5'(cad_pkg::DIV_ITER) && st_q.divCnt != 5'd0) begin
                trial = {st_q.divRem, 1'b0} - {1'b0, st_q.divDen, 16'h0000};
                if (!trial[32]) begin
                    st_d.divRem = {trial[31:0]} | 32'h00000001;
                end else begin
                    st_d.divRem = {st_q.divRem[30:0], 1'b0};
                end
            end
            if (st_q.divCnt == 5'd0) begin
                st_d.divRun = 1'b0;
                // Quotient to work register 0, remainder to work register 1.
                st_d.res[15:0] = st_q.divNegQ ? -st_q.divRem[15:0] : st_q.divRem[15:0];
                st_d.res[31:16] = st_q.divNegR ? -st_q.divRem[31:16] : st_q.divRem[31:16];
            end
            if (divAbort) begin
                st_d.divRun = 1'b0;
            end
        end
        // Read data is loaded by a read address phase and then held until the next read.
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr)
                cad_pkg::ADDR_FLAGS: st_d.rdata = {16'h0000,
                    st_d.flags & cad_pkg::FLAGS_MASK};
                cad_pkg::ADDR_CTRL: st_d.rdata = {16'h0000, st_d.ctrl};
                cad_pkg::ADDR_OP_A: st_d.rdata = {16'h0000, st_d.opA};
                cad_pkg::ADDR_OP_B: st_d.rdata = {16'h0000, st_d.opB};
                cad_pkg::ADDR_OP_HI: st_d.rdata = {16'h0000, st_d.opHi};
                cad_pkg::ADDR_RES_LO: st_d.rdata = {16'h0000, st_d.res[15:0]};
                cad_pkg::ADDR_RES_HI: st_d.rdata = {16'h0000, st_d.res[31:16]};
                cad_pkg::ADDR_BUSY: st_d.rdata = {31'h00000000, st_d.divRun};
                default: st_d.rdata = 32'h00000000;
            endcase
        end
    end

    // State register; every implemented bit clears at reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs driven from the state register; ready and response are tied constant.
    assign hrdata = st_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cpuPriority = {st_q.ctrl[cad_pkg::CTL_PRIORITY_LEVEL_MSB], st_q.flags[cad_pkg::FLG_IPL +: 3]};
    assign userIntDisabled = st_q.ctrl[cad_pkg::CTL_PRIORITY_LEVEL_MSB]
        || (st_q.flags[cad_pkg::FLG_IPL +: 3] == 3'h7);
    assign progWindowEnable = st_q.ctrl[cad_pkg::CTL_PSV];
    assign workReg0 = st_q.res[15:0];
    assign workReg1 = st_q.res[31:16];
    assign divBusy = st_q.divRun;
endmodule
`default_nettype wire

/* File: verif/cad_alu_monitor.sv */
// Port checker for the arithmetic datapath, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module cad_alu_monitor (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bus.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Context and results.
    input wire logic nestingDisable,
    input wire logic ipl3Raise,
    input wire logic divAbort,
    input wire logic [3:0] cpuPriority,
    input wire logic userIntDisabled,
    input wire logic progWindowEnable,
    input wire logic divBusy
);
    localparam int DIV_CYC = 19;
    logic aPh_q;
    logic aWr_q;
    logic [7:0] aAd_q;
    logic [5:0] busyCnt_q;
    logic wrPh;
    logic ctlWr;
    logic flgWr;
    logic flgRd;
    // Data phase decode from the captured address phase.
    assign wrPh = aPh_q && aWr_q;
    assign ctlWr = wrPh && aAd_q == cad_pkg::ADDR_CTRL;
    assign flgWr = wrPh && aAd_q == cad_pkg::ADDR_FLAGS;
    assign flgRd = aPh_q && !aWr_q && aAd_q == cad_pkg::ADDR_FLAGS;
    // Captures each address phase and counts the busy cycles of a divide.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aPh_q <= 1'b0;
            aWr_q <= 1'b0;
            aAd_q <= 8'h00;
            busyCnt_q <= 6'h00;
        end else begin
            aPh_q <= hsel && hready && htrans[1];
            aWr_q <= hwrite;
            aAd_q <= haddr;
            busyCnt_q <= divBusy ? busyCnt_q + 6'h01 : 6'h00;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_divCmd;
        wrPh && aAd_q == cad_pkg::ADDR_CMD && !divBusy && (hwdata[3:0] == 4'hd || hwdata[3:0] == 4'he);
    endsequence
    sequence s_divEnd;
        $fell(divBusy) && !$past(divAbort);
    endsequence
    a_user_mask: assert property (
        userIntDisabled == (cpuPriority[3] || &cpuPriority[2:0]))
        else $error("User interrupt mask disagrees with priority.");
    a_priority_level_msb_set: assert property (ipl3Raise |=> cpuPriority[3])
        else $error("Raise did not set the priority top bit.");
    a_priority_level_msb_clear: assert property (
        $fell(cpuPriority[3]) |-> $past(ctlWr && !hwdata[3] && !ipl3Raise))
        else $error("Priority top bit fell without a software clear.");
    a_prio_write: assert property (
        flgWr && !nestingDisable |=> cpuPriority[2:0] == $past(hwdata[7:5]))
        else $error("Priority bits did not take the written value.");
    a_prio_lock: assert property (flgWr && nestingDisable |=> $stable(cpuPriority[2:0]))
        else $error("Priority bits changed while locked.");
    a_window_wr: assert property (ctlWr |=> progWindowEnable == $past(hwdata[2]))
        else $error("Window enable did not follow the control write.");
    a_div_start: assert property (s_divCmd |=> divBusy)
        else $error("Divide command did not start the divider.");
    a_div_length: assert property (s_divEnd |-> busyCnt_q == DIV_CYC)
        else $error("Divide busy time is wrong.");
    a_div_bound: assert property (busyCnt_q <= DIV_CYC)
        else $error("Divide runs too long.");
    a_flags_zero: assert property (flgRd |-> hrdata[31:9] == 23'h0)
        else $error("Unimplemented flag bits read nonzero.");
endmodule
bind cad_alu_datapath cad_alu_monitor u_mon (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .nestingDisable(nestingDisable),
    .ipl3Raise(ipl3Raise), .divAbort(divAbort), .cpuPriority(cpuPriority),
    .userIntDisabled(userIntDisabled), .progWindowEnable(progWindowEnable), .divBusy(divBusy)
);
`default_nettype wire

/* File: verif/cad_ctx_model.sv */
// Decoder-side model that drives the loop, nesting, raise and abort lines.
`timescale 1ns/1ps
`default_nettype none
module cad_ctx_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Requests from the test sequence.
    input wire logic loopReq,
    input wire logic nestReq,
    input wire logic raiseReq,
    input wire logic abortReq,
    // Context lines into the datapath.
    output logic loopActive,
    output logic nestingDisable,
    output logic ipl3Raise,
    output logic divAbort
);
    // Registers each request so the lines change just after a clock edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loopActive <= 1'b0;
            nestingDisable <= 1'b0;
            ipl3Raise <= 1'b0;
            divAbort <= 1'b0;
        end else begin
            loopActive <= loopReq;
            nestingDisable <= nestReq;
            ipl3Raise <= raiseReq;
            divAbort <= abortReq;
        end
    end
endmodule
`default_nettype wire

/* File: verif/test_cad_alu_datapath.sv */
// Self-checking bench for the arithmetic datapath over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin errorCnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_cad_alu_datapath;
    typedef struct packed {logic [15:0] cmd, a, b; logic [31:0] res; logic [15:0] fl;} cad_vec_s;
    localparam cad_vec_s VECS [19] = '{
        '{16'h0000, 16'h7fff, 16'h0001, 32'h00008000, 16'h010c},
        '{16'h0000, 16'hffff, 16'h0001, 32'h00000000, 16'h0103},
        '{16'h0001, 16'h0000, 16'h0001, 32'h0000ffff, 16'h0008},
        '{16'h0001, 16'h0005, 16'h0003, 32'h00000002, 16'h0101},
        '{16'h0010, 16'h000f, 16'h0001, 32'h00000010, 16'h0100},
        '{16'h0010, 16'h0080, 16'h0080, 32'h00000000, 16'h0007},
        '{16'h0002, 16'hffff, 16'h0000, 32'h00000000, 16'h0007},
        '{16'h0003, 16'h8000, 16'h0001, 32'h00008001, 16'h000d},
        '{16'h0004, 16'haaaa, 16'haaaa, 32'h00000000, 16'h0007},
        '{16'h0f05, 16'h8000, 16'h0000, 32'h0000ffff, 16'h000d},
        '{16'h0f06, 16'h0001, 16'h0000, 32'h00008000, 16'h000d},
        '{16'h0107, 16'hffff, 16'h0000, 32'h00007fff, 16'h0005},
        '{16'h0008, 16'hffff, 16'hffff, 32'h00000001, 16'h0005},
        '{16'h0009, 16'hffff, 16'hffff, 32'hfffe0001, 16'h0005},
        '{16'h000a, 16'hffff, 16'hffff, 32'hffff0001, 16'h0005},
        '{16'h000b, 16'hffff, 16'h0002, 32'hfffffffe, 16'h0005},
        '{16'h0009, 16'h0100, 16'h001f, 32'h00001f00, 16'h0005},
        '{16'h000b, 16'hffff, 16'h001f, 32'hffffffe1, 16'h0005},
        '{16'h000c, 16'h12ff, 16'h34ff, 32'h0000fe01, 16'h0005}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic loopReq = 1'b0, nestReq = 1'b0, raiseReq = 1'b0, abortReq = 1'b0;
    wire hready;
    logic [31:0] hrdata, rd, rh, fr, rMask;
    logic [15:0] fMask, workReg0, workReg1;
    logic hreadyout, hresp, nestingDisable, loopActive, ipl3Raise, divAbort;
    logic userIntDisabled, progWindowEnable, divBusy;
    logic [3:0] cpuPriority;
    int errorCnt = 0;
    int checksDone = 0;
    int cycCnt = 0;
    // The single slave's ready is the bus ready.
    assign hready = hreadyout;
    cad_alu_datapath DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .nestingDisable(nestingDisable),
        .loopActive(loopActive), .ipl3Raise(ipl3Raise), .divAbort(divAbort),
        .cpuPriority(cpuPriority), .userIntDisabled(userIntDisabled),
        .progWindowEnable(progWindowEnable), .workReg0(workReg0), .workReg1(workReg1),
        .divBusy(divBusy));
    cad_ctx_model u_ctx (.clk(clk), .rst(rst), .loopReq(loopReq), .nestReq(nestReq),
        .raiseReq(raiseReq), .abortReq(abortReq), .loopActive(loopActive),
        .nestingDisable(nestingDisable), .ipl3Raise(ipl3Raise), .divAbort(divAbort));
    // Clock of 10 ns period and a cycle ceiling that cuts a hang short.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycCnt++;
        if (cycCnt == 5000) begin
            errorCnt++;
            giveVerdict();
        end
    end
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One single transfer: address phase, then data phase, each held until ready.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rdat);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic putReg(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rh);
    endtask
    task automatic getReg(input logic [7:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask
    // Runs one divide; a poke writes a command that must be ignored while busy.
    task automatic divRun(input logic [15:0] lo, hi, dv, cm, q, r, input bit poke);
        int n;
        putReg(cad_pkg::ADDR_OP_A, {16'h0, lo});
        putReg(cad_pkg::ADDR_OP_HI, {16'h0, hi});
        putReg(cad_pkg::ADDR_OP_B, {16'h0, dv});
        putReg(cad_pkg::ADDR_CMD, {16'h0, cm});
        if (poke) putReg(cad_pkg::ADDR_CMD, 32'h0);
        #1;
        n = 0;
        while (divBusy === 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (!poke) `CHK("divide cycles", cad_pkg::DIV_TOTAL, n)
        `CHK("quotient", q, workReg0)
        `CHK("remainder", r, workReg1)
    endtask
    // Main sequence: registers, priority, operations table, divides.
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        getReg(cad_pkg::ADDR_FLAGS, rd);
        `CHK("flags reset", 32'h0, rd)
        `CHK("okay response", 1'b0, hresp)
        getReg(cad_pkg::ADDR_CTRL, rd);
        `CHK("ctrl reset", 32'h0, rd)
        putReg(8'h24, 32'hffffffff);
        getReg(8'h24, rd);
        `CHK("unmapped", 32'h0, rd)
        putReg(cad_pkg::ADDR_FLAGS, 32'h0000ffff);
        getReg(cad_pkg::ADDR_FLAGS, rd);
        `CHK("flags write", 32'h01ef, rd)
        `CHK("level seven", 2'b11, {cpuPriority == 4'h7, userIntDisabled})
        @(posedge clk);
        nestReq <= 1'b1;
        @(posedge clk);
        putReg(cad_pkg::ADDR_FLAGS, 32'h0);
        getReg(cad_pkg::ADDR_FLAGS, rd);
        `CHK("locked level", 32'h00e0, rd)
        nestReq <= 1'b0;
        loopReq <= 1'b1;
        @(posedge clk);
        putReg(cad_pkg::ADDR_FLAGS, 32'h0060);
        getReg(cad_pkg::ADDR_FLAGS, rd);
        `CHK("loop flag", 32'h0070, rd)
        `CHK("level three", 5'h06, {cpuPriority, userIntDisabled})
        loopReq <= 1'b0;
        putReg(cad_pkg::ADDR_CTRL, 32'h000c);
        getReg(cad_pkg::ADDR_CTRL, rd);
        `CHK("ctrl no set", 32'h0004, rd)
        `CHK("window on", 1'b1, progWindowEnable)
        raiseReq <= 1'b1;
        @(posedge clk);
        raiseReq <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("level eleven", 5'h17, {cpuPriority, userIntDisabled})
        putReg(cad_pkg::ADDR_CTRL, 32'h0);
        getReg(cad_pkg::ADDR_CTRL, rd);
        `CHK("ctrl clear", 32'h0, rd)
        `CHK("cleared level", 6'h0c, {cpuPriority, userIntDisabled, progWindowEnable})
        for (int i = 0; i < 19; i++) begin
            rMask = VECS[i].cmd[3] ? 32'hffffffff : (VECS[i].cmd[4] ? 32'h00ff : 32'hffff);
            fMask = (VECS[i].cmd[3:0] < 4'h2) ? 16'h010f : 16'h000f;
            putReg(cad_pkg::ADDR_OP_A, {16'h0, VECS[i].a});
            putReg(cad_pkg::ADDR_OP_B, {16'h0, VECS[i].b});
            putReg(cad_pkg::ADDR_CMD, {16'h0, VECS[i].cmd});
            getReg(cad_pkg::ADDR_RES_LO, rd);
            getReg(cad_pkg::ADDR_RES_HI, fr);
            `CHK("result", VECS[i].res & rMask, {fr[15:0], rd[15:0]} & rMask)
            getReg(cad_pkg::ADDR_FLAGS, fr);
            `CHK("flags", VECS[i].fl & fMask, fr[15:0] & fMask)
        end
        divRun(16'hfff9, 16'hffff, 16'h0002, 16'h000d, 16'hfffd, 16'hffff, 1'b0);
        divRun(16'h0000, 16'h0001, 16'h0003, 16'h000e, 16'h5555, 16'h0001, 1'b0);
        divRun(16'h0064, 16'hffff, 16'h0007, 16'h001e, 16'h000e, 16'h0002, 1'b0);
        divRun(16'hfff9, 16'h0000, 16'h0002, 16'h001d, 16'hfffd, 16'hffff, 1'b1);
        putReg(cad_pkg::ADDR_CMD, 32'h000e);
        abortReq <= 1'b1;
        @(posedge clk);
        abortReq <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("aborted busy", 1'b0, divBusy)
        giveVerdict();
    end
endmodule
`default_nettype wire
